// ==== hw/pllcg_defs.svh ====
// pllcg_defs.svh: addresses, field positions and reset values of the
// clock generator; definitions only, included by the top module and the testbench.
`ifndef PLLCG_DEFS_SVH
`define PLLCG_DEFS_SVH

// register map, byte address and word index
`define PLLCG_CTL_ADDR      12'h058
`define PLLCG_CTL_WORD      10'h016

// clock_mode_control fields
`define PLLCG_MUL_MSB       15
`define PLLCG_MUL_LSB       12
`define PLLCG_PDIV_BIT      11
`define PLLCG_CNT_MSB       10
`define PLLCG_CNT_LSB       3
`define PLLCG_ON_BIT        2
`define PLLCG_NDIV_BIT      1
`define PLLCG_STAT_BIT      0
`define PLLCG_MUL_MAX       4'hF

// reset values chosen by the strap pins
`define PLLCG_RST_DIV2      16'h0000
`define PLLCG_RST_X10       16'h9007
`define PLLCG_RST_X5        16'h4007
`define PLLCG_RST_X2        16'h1007
`define PLLCG_RST_X1        16'hF007
`define PLLCG_RST_DIV4      16'hF000

// strap patterns {first, second, third}
`define PLLCG_STRAP_000     3'h0
`define PLLCG_STRAP_001     3'h1
`define PLLCG_STRAP_010     3'h2
`define PLLCG_STRAP_100     3'h4
`define PLLCG_STRAP_110     3'h6
`define PLLCG_STRAP_111     3'h7
`define PLLCG_STRAP_101     3'h5

// bus answers
`define PLLCG_RESP_OKAY     2'h0
`define PLLCG_RESP_SLVERR   2'h2

`endif

// ==== hw/pllcg_lock_timer.sv ====
// pllcg_lock_timer: counts a programmed lock time before pll clocking.
// assumes load is a one-cycle pulse from the mode controller.
`timescale 1ns/100ps
`default_nettype none
module pllcg_lock_timer
    import pllcg_pkg::*;
#(
    parameter int CNT_W     = 8,
    parameter int TICK      = 16
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // control
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_value,
    // status
    output logic                  running,
    output logic                  done
);

    localparam int PRE_W = $clog2(TICK + 1);
    localparam logic [PRE_W-1:0] PRE_TOP = PRE_W'(TICK - 1);

    logic [CNT_W-1:0] remain;
    logic [PRE_W-1:0] pre;

    // reload wins over a pending expiry so a stale count never fires
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            running <= 1'b0;
            done    <= 1'b0;
            remain  <= '0;
            pre     <= '0;
        end else if (load) begin
            running <= 1'b1;
            done    <= 1'b0;
            remain  <= load_value;
            pre     <= PRE_TOP;
        end else if (running) begin
            if (remain == '0) begin
                running <= 1'b0;
                done    <= 1'b1;
            end else if (pre == '0) begin
                remain  <= remain - 1'b1;
                pre     <= PRE_TOP;
            end else begin
                pre     <= pre - 1'b1;
            end
        end else begin
            done <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== hw/pllcg_pkg.sv ====
// pllcg_pkg: types shared by the clock generator modules.
// assumes nothing beyond a SystemVerilog compiler.
package pllcg_pkg;

    typedef enum logic [1:0] {
        PLLCG_MODE_DIV  = 2'b00,
        PLLCG_MODE_LOCK = 2'b01,
        PLLCG_MODE_PLL  = 2'b10
    } pllcg_mode_t;

endpackage

// ==== hw/pllcg_rate_gen.sv ====
// pllcg_rate_gen: makes the master clock from the sampled reference.
// assumes ref_in is synchronous to aclk and slower than aclk / 2.
`timescale 1ns/100ps
`default_nettype none
module pllcg_rate_gen
    import pllcg_pkg::*;
#(
    parameter int PER_W = 16
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // reference and mode
    input  wire logic       ref_in,
    input  wire logic       pll_mode,
    input  wire logic       div4,
    input  wire logic [4:0] ratio_num,
    input  wire logic [1:0] ratio_shift,
    // master clock
    output logic            tick,
    output logic            master_clock
);

    localparam int ACC_W = PER_W + 3;

    logic             ref_q;
    logic             rise;
    logic [PER_W-1:0] cnt;
    logic [PER_W-1:0] period;
    logic [1:0]       edges;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] acc_sum;
    logic [ACC_W-1:0] thr;
    logic             pll_hit;
    logic             div_hit;

    assign rise    = ref_in & ~ref_q;
    assign acc_sum = acc + ACC_W'(ratio_num);
    assign thr     = ACC_W'(period) << ratio_shift;
    assign pll_hit = (thr != '0) && (acc_sum >= thr);
    assign div_hit = rise && (div4 ? (edges == 2'h3) : edges[0]);

    // reference period in aclk cycles; count saturates, period then wraps to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_q  <= 1'b0;
            cnt    <= '0;
            period <= '0;
        end else begin
            ref_q <= ref_in;
            if (rise) begin
                period <= cnt + 1'b1;
                cnt    <= '0;
            end else if (cnt != '1) begin
                cnt <= cnt + 1'b1;
            end
        end
    end

    // divider path: every second or fourth reference edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edges <= '0;
        end else if (rise) begin
            edges <= edges + 1'b1;
        end
    end

    // pll path: num ticks per (period << shift) cycles
    always_ff @(posedge aclk) begin
        if (!aresetn || !pll_mode) begin
            acc <= '0;
        end else if (pll_hit) begin
            acc <= acc_sum - thr;
        end else begin
            acc <= acc_sum;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick         <= 1'b0;
            master_clock <= 1'b0;
        end else begin
            tick <= pll_mode ? pll_hit : div_hit;
            if (pll_mode ? pll_hit : div_hit) begin
                master_clock <= ~master_clock;
            end
        end
    end

endmodule
`default_nettype wire

// ==== hw/pllcg_top.sv ====
// pllcg_top: clock mode register, strap reset, lock sequencing and
// the axi4-lite slave that reaches the register.
// assumes straps and reference are synchronous to aclk.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pllcg_defs.svh"

module pllcg_top
    import pllcg_pkg::*;
#(
    parameter int LOCK_TICK = 16,
    parameter int PER_W     = 16
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // strap pins and reference
    input  wire logic        clock_strap_first,
    input  wire logic        clock_strap_second,
    input  wire logic        clock_strap_third,
    input  wire logic        reference_clock_input,
    // axi4-lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // clock outputs
    output logic             master_clock,
    output logic             master_clock_tick,
    output logic             pll_enable,
    output logic             oscillator_enable,
    output logic             pll_clock_active
);

    logic [2:0]  strap;
    logic [15:0] strap_value;
    logic [15:0] ctl;
    logic [15:0] next_ctl;
    logic [15:0] ctl_rd;
    pllcg_mode_t mode;
    pllcg_mode_t next_mode;
    logic        aw_held;
    logic [11:0] aw_addr_q;
    logic        w_held;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic        wr_hit;
    logic        cfg_write;
    logic        ar_fire;
    logic        ar_hit;
    logic        next_aw_held;
    logic        next_w_held;
    logic        next_bvalid;
    logic        next_rvalid;
    logic        ratio_change;
    logic        timer_load;
    logic        timer_done;
    logic [3:0]  mul;
    logic        pdiv;
    logic [4:0]  ratio_num;
    logic [1:0]  ratio_shift;
    logic        div4;
    logic        gen_tick;
    logic        gen_clock;

    assign strap = {clock_strap_first, clock_strap_second, clock_strap_third};

    // reset value selected by the straps
    always_comb begin
        unique case (strap)
            `PLLCG_STRAP_000: strap_value = `PLLCG_RST_DIV2;
            `PLLCG_STRAP_001: strap_value = `PLLCG_RST_X10;
            `PLLCG_STRAP_010: strap_value = `PLLCG_RST_X5;
            `PLLCG_STRAP_100: strap_value = `PLLCG_RST_X2;
            `PLLCG_STRAP_110: strap_value = `PLLCG_RST_X1;
            `PLLCG_STRAP_111: strap_value = `PLLCG_RST_DIV2;
            `PLLCG_STRAP_101: strap_value = `PLLCG_RST_DIV4;
            default:          strap_value = `PLLCG_RST_DIV2;
        endcase
    end

    // ---------------- write channel ----------------
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
    assign wr_hit  = (aw_addr_q[11:2] == `PLLCG_CTL_WORD);
    assign cfg_write = wr_fire & wr_hit;

    assign next_aw_held = wr_fire ? 1'b0 : (aw_held | (s_axi_awvalid & s_axi_awready));
    assign next_w_held  = wr_fire ? 1'b0 : (w_held | (s_axi_wvalid & s_axi_wready));
    assign next_bvalid  = wr_fire | (s_axi_bvalid & ~s_axi_bready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            aw_addr_q <= '0;
        end else begin
            aw_held <= next_aw_held;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held   <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else begin
            w_held <= next_w_held;
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PLLCG_RESP_OKAY;
        end else begin
            s_axi_awready <= ~next_aw_held & ~next_bvalid;
            s_axi_wready  <= ~next_w_held & ~next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (wr_fire) begin
                s_axi_bresp <= wr_hit ? `PLLCG_RESP_OKAY : `PLLCG_RESP_SLVERR;
            end
        end
    end

    // ---------------- read channel ----------------
    assign ar_fire     = s_axi_arvalid & s_axi_arready;
    assign ar_hit      = (s_axi_araddr[11:2] == `PLLCG_CTL_WORD);
    assign next_rvalid = ar_fire | (s_axi_rvalid & ~s_axi_rready);

    // status bit shows live pll clocking
    always_comb begin
        ctl_rd = ctl;
        ctl_rd[`PLLCG_STAT_BIT] = (mode == PLLCG_MODE_PLL);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `PLLCG_RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_fire) begin
                s_axi_rdata <= ar_hit ? {16'h0000, ctl_rd} : 32'h00000000;
                s_axi_rresp <= ar_hit ? `PLLCG_RESP_OKAY : `PLLCG_RESP_SLVERR;
            end
        end
    end

    // ---------------- clock mode register ----------------
    always_comb begin
        next_ctl = ctl;
        if (cfg_write) begin
            if (w_strb_q[0]) begin
                next_ctl[7:1] = w_data_q[7:1];
            end
            if (w_strb_q[1]) begin
                next_ctl[15:8] = w_data_q[15:8];
            end
        end
    end

    // straps load while reset is low, only software after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl <= strap_value;
        end else begin
            ctl <= next_ctl;
        end
    end

    // ---------------- ratio decode ----------------
    assign mul  = next_ctl[`PLLCG_MUL_MSB:`PLLCG_MUL_LSB];
    assign pdiv = next_ctl[`PLLCG_PDIV_BIT];
    assign ratio_change = (next_ctl[`PLLCG_MUL_MSB:`PLLCG_PDIV_BIT]
                           != ctl[`PLLCG_MUL_MSB:`PLLCG_PDIV_BIT]);

    // 15 integer ratios, 15 halves, plus one quarter: 31 in all
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ratio_num   <= 5'h01;
            ratio_shift <= 2'h0;
            div4        <= 1'b0;
        end else begin
            ratio_num   <= (mul == `PLLCG_MUL_MAX) ? 5'h01 : 5'({1'b0, mul} + 5'h01);
            ratio_shift <= pdiv ? ((mul == `PLLCG_MUL_MAX) ? 2'h2 : 2'h1) : 2'h0;
            div4        <= (mul == `PLLCG_MUL_MAX);
        end
    end

    // ---------------- mode sequencing ----------------
    always_comb begin
        next_mode  = mode;
        timer_load = 1'b0;
        unique case (mode)
            PLLCG_MODE_DIV: begin
                if (cfg_write && next_ctl[`PLLCG_NDIV_BIT]) begin
                    next_mode  = PLLCG_MODE_LOCK;
                    timer_load = 1'b1;
                end
            end
            PLLCG_MODE_LOCK: begin
                if (cfg_write && !next_ctl[`PLLCG_NDIV_BIT]) begin
                    next_mode = PLLCG_MODE_DIV;
                end else if (cfg_write) begin
                    timer_load = 1'b1;
                end else if (timer_done) begin
                    next_mode = PLLCG_MODE_PLL;
                end
            end
            PLLCG_MODE_PLL: begin
                if (cfg_write && !next_ctl[`PLLCG_NDIV_BIT]) begin
                    next_mode = PLLCG_MODE_DIV;
                end else if (cfg_write && ratio_change) begin
                    next_mode  = PLLCG_MODE_LOCK;
                    timer_load = 1'b1;
                end
            end
            default: begin
                next_mode = PLLCG_MODE_DIV;
            end
        endcase
    end

    // strapped pll ratios carry a zero lock count, so start locked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= strap_value[`PLLCG_NDIV_BIT] ? PLLCG_MODE_PLL : PLLCG_MODE_DIV;
        end else begin
            mode <= next_mode;
        end
    end

    pllcg_lock_timer #(
        .CNT_W      (`PLLCG_CNT_MSB - `PLLCG_CNT_LSB + 1),
        .TICK       (LOCK_TICK)
    ) u_lock (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .load       (timer_load),
        .load_value (next_ctl[`PLLCG_CNT_MSB:`PLLCG_CNT_LSB]),
        .running    (),
        .done       (timer_done)
    );

    pllcg_rate_gen #(
        .PER_W       (PER_W)
    ) u_gen (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .ref_in      (reference_clock_input),
        .pll_mode    (mode == PLLCG_MODE_PLL),
        .div4        (div4),
        .ratio_num   (ratio_num),
        .ratio_shift (ratio_shift),
        .tick        (gen_tick),
        .master_clock(gen_clock)
    );

    // ---------------- outputs ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_clock      <= 1'b0;
            master_clock_tick <= 1'b0;
        end else begin
            master_clock      <= gen_clock;
            master_clock_tick <= gen_tick;
        end
    end

    // pll powered when forced on or when pll clocking is wanted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pll_enable       <= 1'b0;
            pll_clock_active <= 1'b0;
        end else begin
            pll_enable       <= ctl[`PLLCG_ON_BIT] | ctl[`PLLCG_NDIV_BIT];
            pll_clock_active <= (mode == PLLCG_MODE_PLL);
        end
    end

    // no reset term: oscillator tracks straps even during reset
    always_ff @(posedge aclk) begin
        oscillator_enable <= (strap != `PLLCG_STRAP_000);
    end

endmodule
`default_nettype wire

// ==== tb/pllcg_chk.sv ====
// pllcg_chk: port assertions for pllcg_top.
// assumes the bind below and inputs synchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module pllcg_chk #(
    parameter int LOCK_TICK = 16
) (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // straps
    input wire logic        clock_strap_first,
    input wire logic        clock_strap_second,
    input wire logic        clock_strap_third,
    // register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // status
    input wire logic        oscillator_enable,
    input wire logic        pll_clock_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // lock request long enough to outlast eight cycles
    sequence s_lock_req;
        s_wr ##0 (s_axi_awaddr[11:2] == 10'h016 && s_axi_wstrb[0] && s_axi_wdata[1]
            && int'(s_axi_wdata[10:3]) * LOCK_TICK >= 12 && !pll_clock_active);
    endsequence

    property p_osc;
        1'b1 |=> oscillator_enable ==
            ($past({clock_strap_first, clock_strap_second, clock_strap_third}) != 3'h0);
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator enable off straps");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_bans;
        s_wr |-> ##2 s_axi_bvalid;
    endproperty
    a_bans: assert property (p_bans) else $error("write response late");
    property p_rans;
        s_rd |=> s_axi_rvalid;
    endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_rmap;
        s_rd ##0 s_axi_araddr[11:2] == 10'h016 |=> s_axi_rresp == 2'h0
            && s_axi_rdata[31:16] == 16'h0;
    endproperty
    a_rmap: assert property (p_rmap) else $error("mapped read answer wrong");
    property p_runmap;
        s_rd ##0 s_axi_araddr[11:2] != 10'h016 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_runmap: assert property (p_runmap) else $error("unmapped read answer wrong");
    property p_bref;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_bref: assert property (p_bref) else $error("write taken while response pending");
    property p_rref;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rref: assert property (p_rref) else $error("read taken while data pending");
    property p_lock;
        s_lock_req |=> !pll_clock_active [*8];
    endproperty
    a_lock: assert property (p_lock) else $error("pll clocking before lock count");
endmodule

bind pllcg_top pllcg_chk #(.LOCK_TICK(LOCK_TICK)) i_chk (
    .aclk, .aresetn, .clock_strap_first, .clock_strap_second, .clock_strap_third,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .oscillator_enable, .pll_clock_active
);
`default_nettype wire

// ==== tb/tb_top.sv ====
// tb_top: strap reset, lock timing, clock rates and bus answers of pllcg_top.
// assumes design files and pllcg_chk are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "pllcg_defs.svh"
module tb_top;
    localparam int LT = 4;
    logic        aclk, aresetn, reference_clock_input;
    logic        clock_strap_first, clock_strap_second, clock_strap_third;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, w;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, master_clock, master_clock_tick;
    logic        pll_enable, oscillator_enable, pll_clock_active, pm;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          n, t, e;
    logic [2:0]  s_tab [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h5};
    logic [15:0] v_tab [7] = '{`PLLCG_RST_DIV2, `PLLCG_RST_X10, `PLLCG_RST_X5,
        `PLLCG_RST_X2, `PLLCG_RST_X1, `PLLCG_RST_DIV2, `PLLCG_RST_DIV4};

    pllcg_top #(.LOCK_TICK(LT)) i_dut (
        .aclk, .aresetn, .clock_strap_first, .clock_strap_second, .clock_strap_third,
        .reference_clock_input, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .master_clock, .master_clock_tick, .pll_enable,
        .oscillator_enable, .pll_clock_active
    );

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // reference, period of 40 aclk cycles
    initial begin
        reference_clock_input = 1'b0;
        forever begin
            repeat (20) @(posedge aclk);
            reference_clock_input <= ~reference_clock_input;
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic check_near(input string nm, input int ex, input int got, input int tol);
        num_checks++;
        if (got < ex - tol || got > ex + tol) begin
            error_cnt++;
            $display("[ERR] %s expected %0d seen %0d", nm, ex, got);
        end
    endtask

    task automatic wait_hi(ref logic s, input string nm);
        int k;
        k = 0;
        do begin
            @(negedge aclk);
            k++;
            if (k > 100) begin
                error_cnt++;
                $display("[ERR] %s expected 1 seen timeout", nm);
                tally_and_finish();
            end
        end while (s !== 1'b1);
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic pa, pw, ha, hw;
        int   k = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        {pa, pw} = 2'b11;
        while ((pa || pw) && k++ < 100) begin
            @(negedge aclk);
            ha = pa && s_axi_awready === 1'b1;
            hw = pw && s_axi_wready === 1'b1;
            @(posedge aclk);
            if (ha) begin
                s_axi_awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (hw) begin
                s_axi_wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        wait_hi(s_axi_bvalid, "bvalid");
        rs = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic bus_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        wait_hi(s_axi_arready, "arready");
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        wait_hi(s_axi_rvalid, "rvalid");
        v = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic strap_reset(input logic [2:0] s);
        @(posedge aclk);
        aresetn <= 1'b0;
        {clock_strap_first, clock_strap_second, clock_strap_third} <= s;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    initial begin
        aresetn = 1'b0;
        {clock_strap_first, clock_strap_second, clock_strap_third} = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        s_axi_wstrb = 4'hF;
        // strap table; straps move after release
        for (int i = 0; i < 7; i++) begin
            strap_reset(s_tab[i]);
            @(posedge aclk);
            {clock_strap_first, clock_strap_second, clock_strap_third} <= ~s_tab[i];
            bus_rd(`PLLCG_CTL_ADDR, d, r);
            check_val("reset value", {16'h0, v_tab[i]}, d);
            check_val("read resp", `PLLCG_RESP_OKAY, r);
            check_val("osc enable", ~s_tab[i] != 3'h0, oscillator_enable);
            check_val("pll active", v_tab[i][0], pll_clock_active);
            check_val("pll enable", v_tab[i][2], pll_enable);
        end
        // every pll ratio, then divide by two and four
        for (int k = 0; k < 34; k++) begin
            w = (k < 32) ? {16'h0, k[4:1], k[0], 11'h002} : (k == 32) ? 32'h0 : 32'hF001;
            e = (k == 32) ? 10 : (k == 33) ? 5 : (k[4:1] == 4'hF) ? (k[0] ? 5 : 20)
                : (k / 2 + 1) * 20 >> k[0];
            bus_wr(`PLLCG_CTL_ADDR, w, r);
            repeat (120) @(posedge aclk);
            n = 0;
            t = 0;
            pm = master_clock;
            repeat (800) begin
                @(negedge aclk);
                if (master_clock_tick === 1'b1) n++;
                if (master_clock !== pm) t++;
                pm = master_clock;
            end
            check_near("tick count", e, n, 2);
            check_near("master clock toggles", e, t, 3);
        end
        // unmapped word, status bit read-only
        bus_wr(12'h05C, 32'h1002, r);
        check_val("unmapped write resp", `PLLCG_RESP_SLVERR, r);
        bus_rd(12'h05C, d, r);
        check_val("unmapped read resp", `PLLCG_RESP_SLVERR, r);
        check_val("unmapped read data", 32'h0, d);
        bus_rd(`PLLCG_CTL_ADDR, d, r);
        check_val("register kept", 32'hF000, d);
        // lock wait scales with the programmed count
        for (int c = 4; c <= 16; c += 12) begin
            bus_wr(`PLLCG_CTL_ADDR, 32'h0, r);
            repeat (4) @(posedge aclk);
            check_val("divider active", 1'b0, pll_clock_active);
            w = {16'h0, 4'h9, 1'b0, c[7:0], 3'b010};
            bus_wr(`PLLCG_CTL_ADDR, w, r);
            check_val("write resp", `PLLCG_RESP_OKAY, r);
            n = 0;
            while (pll_clock_active !== 1'b1 && n < 300) begin
                @(negedge aclk);
                n++;
            end
            check_near("lock wait", c * LT, n, 6);
            bus_rd(`PLLCG_CTL_ADDR, d, r);
            check_val("locked value", w | 32'h1, d);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
